// File: design/rcr_base_match.v
`default_nettype none

// Compares a host address against a programmed base. The block is
// disabled while the enable bits of the base are all zero.
module rcr_base_match #(
  parameter W = 8,
  parameter EN_BITS = 2
) (
  input wire [W-1:0] base,
  input wire [W-1:0] addr_hi,
  input wire chip_select_n,
  input wire upper_ok,
  output wire enabled,
  output wire hit
);
  assign enabled = |base[W-1:W-EN_BITS];
  assign hit = enabled && !chip_select_n && upper_ok && (addr_hi == base);
endmodule

`default_nettype wire

// File: design/rcr_config_regs.v
`include "rcr_defines.vh"
`default_nettype none

module rcr_config_regs #(
  parameter [14:0] TA_STEP_CYCLES = `RCR_TA_STEP_CYCLES
) (
  input wire sys_clk,
  input wire rst,
  input wire clk_en,
  input wire config_mode,
  input wire [7:0] config_index_register,
  input wire cfg_wr_en,
  input wire cfg_rd_en,
  input wire [7:0] cfg_wdata,
  output reg [7:0] cfg_rdata,
  output reg cfg_rd_hit,
  input wire chip_select_n,
  input wire [10:0] host_addr,
  output wire second_serial_port_sel,
  output wire [2:0] second_serial_port_reg,
  output wire second_serial_port_enabled,
  output wire fast_ir_engine_sel,
  output wire [2:0] fast_ir_engine_reg,
  output wire fast_ir_engine_enabled,
  input wire disk_controller_drq,
  input wire parallel_drq,
  input wire fast_ir_engine_drq,
  output wire [2:0] dma_request_output,
  output wire [2:0] dma_request_oe,
  input wire disk_controller_irq,
  input wire parallel_irq,
  input wire first_serial_port_irq,
  input wire first_serial_gate,
  input wire second_serial_port_irq,
  input wire second_serial_gate,
  input wire external_interrupt_input,
  output wire [6:0] irq_line_out,
  output wire [6:0] irq_line_oe,
  output reg ir_pin_function_select,
  input wire engine_ta_wr_en,
  input wire [7:0] engine_ta_wdata,
  output reg [7:0] ir_turnaround_timeout,
  output reg [22:0] ir_turnaround_cycles
);

  localparam ND = `RCR_DMA_LINES;
  localparam NI = `RCR_IRQ_LINES;

  reg [7:0] second_serial_base;
  reg [7:0] disk_parallel_dma_route;
  reg [7:0] disk_parallel_irq_route;
  reg [7:0] serial_irq_route;
  reg [7:0] ir_pin_mode_and_irq_input;
  reg [7:0] fast_ir_base;
  reg [7:0] fast_ir_dma_route;
  reg [7:0] next_rdata;
  reg next_hit;

  wire cfg_wr;
  wire cfg_rd;
  wire serial_share;

  // A strobe counts only while the device is in the configuration state
  assign cfg_wr = clk_en && config_mode && cfg_wr_en;
  assign cfg_rd = clk_en && config_mode && cfg_rd_en;

  function wr_to;
    input [7:0] idx;
    begin
      wr_to = cfg_wr && (config_index_register == idx);
    end
  endfunction

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      second_serial_base <= `RCR_RST_SER2_BASE;
      disk_parallel_dma_route <= `RCR_RST_DP_DMA;
      disk_parallel_irq_route <= `RCR_RST_DP_IRQ;
      serial_irq_route <= `RCR_RST_SER_IRQ;
      ir_pin_mode_and_irq_input <= `RCR_RST_IR_MODE;
      fast_ir_base <= `RCR_RST_FIR_BASE;
      fast_ir_dma_route <= `RCR_RST_FIR_DMA;
    end
    else if (clk_en)
    begin
      // Bit 0 of the serial-two base is not an address bit
      if (wr_to(`RCR_IDX_SER2_BASE))
        second_serial_base <= cfg_wdata & `RCR_SER2_MASK;
      if (wr_to(`RCR_IDX_DP_DMA))
        disk_parallel_dma_route <= cfg_wdata;
      if (wr_to(`RCR_IDX_DP_IRQ))
        disk_parallel_irq_route <= cfg_wdata;
      if (wr_to(`RCR_IDX_SER_IRQ))
        serial_irq_route <= cfg_wdata;
      if (wr_to(`RCR_IDX_IR_MODE))
        ir_pin_mode_and_irq_input <= cfg_wdata & `RCR_IR_MODE_MASK;
      if (wr_to(`RCR_IDX_FIR_BASE))
        fast_ir_base <= cfg_wdata;
      if (wr_to(`RCR_IDX_FIR_DMA))
        fast_ir_dma_route <= cfg_wdata & `RCR_FIR_DMA_MASK;
    end
  end

  // One register serves as both twins, so the two can never disagree.
  // A configuration write beats an engine write in the same cycle.
  always @(posedge sys_clk)
  begin
    if (rst)
      ir_turnaround_timeout <= `RCR_RST_TURNAROUND;
    else if (clk_en)
    begin
      if (wr_to(`RCR_IDX_TURNAROUND))
        ir_turnaround_timeout <= cfg_wdata;
      else if (engine_ta_wr_en)
        ir_turnaround_timeout <= engine_ta_wdata;
    end
  end

  // Timeout length in clock cycles, one cycle behind the register
  always @(posedge sys_clk)
  begin
    if (rst)
      ir_turnaround_cycles <= 23'h000000;
    else if (clk_en)
      // Both operands widened to the result so the product is not cut
      ir_turnaround_cycles <= {15'h0000, ir_turnaround_timeout}
        * {8'h00, TA_STEP_CYCLES};
  end

  always @(posedge sys_clk)
  begin
    if (rst)
      ir_pin_function_select <= 1'b0;
    else if (clk_en)
      ir_pin_function_select <=
        ir_pin_mode_and_irq_input[`RCR_IR_PIN_SEL_BIT];
  end

  // Read path: data and hit appear on the edge after the read strobe
  always @*
  begin
    next_rdata = 8'h00;
    next_hit = 1'b1;
    case (config_index_register)
      `RCR_IDX_SER2_BASE: next_rdata = second_serial_base;
      `RCR_IDX_DP_DMA: next_rdata = disk_parallel_dma_route;
      `RCR_IDX_DP_IRQ: next_rdata = disk_parallel_irq_route;
      `RCR_IDX_SER_IRQ: next_rdata = serial_irq_route;
      `RCR_IDX_IR_MODE: next_rdata = ir_pin_mode_and_irq_input;
      `RCR_IDX_RSVD: next_rdata = 8'h00;
      `RCR_IDX_FIR_BASE: next_rdata = fast_ir_base;
      `RCR_IDX_FIR_DMA: next_rdata = fast_ir_dma_route;
      `RCR_IDX_TURNAROUND: next_rdata = ir_turnaround_timeout;
      default: next_hit = 1'b0;
    endcase
  end

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      cfg_rdata <= 8'h00;
      cfg_rd_hit <= 1'b0;
    end
    else if (clk_en)
    begin
      cfg_rd_hit <= cfg_rd && next_hit;
      if (cfg_rd && next_hit)
        cfg_rdata <= next_rdata;
      else
        cfg_rdata <= 8'h00;
    end
  end

  // Host address decode of the two relocatable blocks
  rcr_base_match #(
    .W(7),
    .EN_BITS(2)
  ) u_ser2_match (
    .base(second_serial_base[`RCR_SER2_ADDR]),
    .addr_hi(host_addr[9:3]),
    .chip_select_n(chip_select_n),
    .upper_ok(!host_addr[10]),
    .enabled(second_serial_port_enabled),
    .hit(second_serial_port_sel)
  );

  assign second_serial_port_reg = host_addr[2:0];

  rcr_base_match #(
    .W(8),
    .EN_BITS(3)
  ) u_fir_match (
    .base(fast_ir_base),
    .addr_hi(host_addr[10:3]),
    .chip_select_n(chip_select_n),
    .upper_ok(1'b1),
    .enabled(fast_ir_engine_enabled),
    .hit(fast_ir_engine_sel)
  );

  assign fast_ir_engine_reg = host_addr[2:0];

  // DMA routing
  wire [ND-1:0] dma_sel_disk;
  wire [ND-1:0] dma_sel_par;
  wire [ND-1:0] dma_sel_fir;

  rcr_route_decode #(
    .N(ND),
    .IRQ_STYLE(0)
  ) u_dma_disk (
    .code(disk_parallel_dma_route[`RCR_HI_FIELD]),
    .sel(dma_sel_disk)
  );

  rcr_route_decode #(
    .N(ND),
    .IRQ_STYLE(0)
  ) u_dma_par (
    .code(disk_parallel_dma_route[`RCR_LO_FIELD]),
    .sel(dma_sel_par)
  );

  rcr_route_decode #(
    .N(ND),
    .IRQ_STYLE(0)
  ) u_dma_fir (
    .code(fast_ir_dma_route[`RCR_LO_FIELD]),
    .sel(dma_sel_fir)
  );

  assign dma_request_oe = dma_sel_disk | dma_sel_par | dma_sel_fir;
  assign dma_request_output = (dma_sel_disk & {ND{disk_controller_drq}})
    | (dma_sel_par & {ND{parallel_drq}})
    | (dma_sel_fir & {ND{fast_ir_engine_drq}});

  // Interrupt routing
  wire [NI-1:0] irq_sel_disk;
  wire [NI-1:0] irq_sel_par;
  wire [NI-1:0] irq_sel_s1;
  wire [NI-1:0] irq_sel_s2;
  wire [NI-1:0] irq_sel_ext;
  wire [NI-1:0] irq_sel_s2_used;
  wire s1_value;
  wire s2_value;

  rcr_route_decode #(
    .N(NI),
    .IRQ_STYLE(1)
  ) u_irq_disk (
    .code(disk_parallel_irq_route[`RCR_HI_FIELD]),
    .sel(irq_sel_disk)
  );

  rcr_route_decode #(
    .N(NI),
    .IRQ_STYLE(1)
  ) u_irq_par (
    .code(disk_parallel_irq_route[`RCR_LO_FIELD]),
    .sel(irq_sel_par)
  );

  rcr_route_decode #(
    .N(NI),
    .IRQ_STYLE(1)
  ) u_irq_s1 (
    .code(serial_irq_route[`RCR_HI_FIELD]),
    .sel(irq_sel_s1)
  );

  rcr_route_decode #(
    .N(NI),
    .IRQ_STYLE(1)
  ) u_irq_s2 (
    .code(serial_irq_route[`RCR_LO_FIELD]),
    .sel(irq_sel_s2)
  );

  rcr_route_decode #(
    .N(NI),
    .IRQ_STYLE(1)
  ) u_irq_ext (
    .code(ir_pin_mode_and_irq_input[`RCR_LO_FIELD]),
    .sel(irq_sel_ext)
  );

  // Code 1111b decodes to no line, so serial two drives nothing of its own
  assign serial_share =
    (serial_irq_route[`RCR_LO_FIELD] == `RCR_IRQ_SHARE);
  assign irq_sel_s2_used = serial_share ? {NI{1'b0}} : irq_sel_s2;

  // A gated-off port reads as deasserted; the level there is a don't-care
  assign s1_value = serial_share
    ? ((first_serial_gate && first_serial_port_irq)
       || (second_serial_gate && second_serial_port_irq))
    : (first_serial_gate && first_serial_port_irq);
  assign s2_value = second_serial_gate && second_serial_port_irq;

  // Lines with two sources simply OR them; keeping them apart is the
  // driver software's job.
  assign irq_line_oe = irq_sel_disk | irq_sel_par | irq_sel_s1
    | irq_sel_s2_used | irq_sel_ext;
  assign irq_line_out = (irq_sel_disk & {NI{disk_controller_irq}})
    | (irq_sel_par & {NI{parallel_irq}})
    | (irq_sel_s1 & {NI{s1_value}})
    | (irq_sel_s2_used & {NI{s2_value}})
    | (irq_sel_ext & {NI{external_interrupt_input}});

endmodule

`default_nettype wire

// File: design/rcr_route_decode.v
`default_nettype none

// Turns a four-bit route code into a one-hot line select.
// Line n is code n+1; in IRQ style code 1000 selects the last line
// and 0111 selects nothing.
module rcr_route_decode #(
  parameter N = 3,
  parameter IRQ_STYLE = 0
) (
  input wire [3:0] code,
  output reg [N-1:0] sel
);
  integer i;
  always @*
  begin
    sel = {N{1'b0}};
    for (i = 0; i < N; i = i + 1)
    begin
      if (IRQ_STYLE != 0 && i == N - 1)
      begin
        if (code == 4'h8)
          sel[i] = 1'b1;
      end
      else if (code == i[3:0] + 4'h1)
        sel[i] = 1'b1;
    end
  end
endmodule

`default_nettype wire

// File: shared/rcr_defines.vh
`ifndef RCR_DEFINES_VH
`define RCR_DEFINES_VH

// Configuration indices of this register group
`define RCR_IDX_SER2_BASE 8'h25
`define RCR_IDX_DP_DMA 8'h26
`define RCR_IDX_DP_IRQ 8'h27
`define RCR_IDX_SER_IRQ 8'h28
`define RCR_IDX_IR_MODE 8'h29
`define RCR_IDX_RSVD 8'h2A
`define RCR_IDX_FIR_BASE 8'h2B
`define RCR_IDX_FIR_DMA 8'h2C
`define RCR_IDX_TURNAROUND 8'h2D

// Power-up values
`define RCR_RST_SER2_BASE 8'h00
`define RCR_RST_DP_DMA 8'h00
`define RCR_RST_DP_IRQ 8'h00
`define RCR_RST_SER_IRQ 8'h00
`define RCR_RST_IR_MODE 8'h00
`define RCR_RST_FIR_BASE 8'h00
`define RCR_RST_FIR_DMA 8'h00
`define RCR_RST_TURNAROUND 8'h03

// Field positions
`define RCR_HI_FIELD 7:4
`define RCR_LO_FIELD 3:0
`define RCR_SER2_ADDR 7:1
`define RCR_IR_PIN_SEL_BIT 4
`define RCR_IR_MODE_MASK 8'h1F
`define RCR_FIR_DMA_MASK 8'h0F
`define RCR_SER2_MASK 8'hFE

// Route codes
`define RCR_ROUTE_NONE 4'h0
`define RCR_IRQ_CODE_H 4'h8
`define RCR_IRQ_SHARE 4'hF

// Line counts
`define RCR_DMA_LINES 3
`define RCR_IRQ_LINES 7

// Timing
`define RCR_TA_STEP_US 100
`define RCR_CLK_MHZ 250
// One turnaround step in clock cycles: 100 us at 250 MHz
`define RCR_TA_STEP_CYCLES 15'h61A8

`endif

// File: sim/rcr_host_side.sv
`default_nettype none
// Host-side controllers see the shared lines through pull-downs, so a
// released line reads low rather than keeping its last value.
module rcr_host_side (
  input wire logic [6:0] irq_out,
  input wire logic [6:0] irq_oe,
  input wire logic [2:0] drq_out,
  input wire logic [2:0] drq_oe,
  output logic [6:0] irq_pin,
  output logic [2:0] drq_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  assign irq_pin = irq_out & irq_oe;
  assign drq_pin = drq_out & drq_oe;
endmodule
`default_nettype wire

// File: sim/rcr_monitor.sv
`default_nettype none
module rcr_monitor #(
  parameter [14:0] TA_STEP_CYCLES = 15'h0004
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic config_mode,
  input wire logic [7:0] config_index_register,
  input wire logic cfg_wr_en,
  input wire logic cfg_rd_en,
  input wire logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata,
  input wire logic cfg_rd_hit,
  input wire logic chip_select_n,
  input wire logic [10:0] host_addr,
  input wire logic second_serial_port_sel,
  input wire logic fast_ir_engine_sel,
  input wire logic ir_pin_function_select,
  input wire logic [7:0] ir_turnaround_timeout,
  input wire logic [22:0] ir_turnaround_cycles
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] pidx;
  wire acc = clk_en && config_mode;
  wire w29 = acc && cfg_wr_en && config_index_register == 8'h29;
  // Index of the last enabled edge, so a frozen cycle cannot skew it
  always @(posedge sys_clk)
    if (clk_en)
      pidx <= config_index_register;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_rd_hit_taken: assert property (
    acc && cfg_rd_en && config_index_register inside {[8'h25:8'h2D]}
    |=> cfg_rd_hit) else $error("read in group not answered");
  a_rd_refused: assert property (
    clk_en && !(config_mode && cfg_rd_en)
    |=> !cfg_rd_hit && cfg_rdata == 8'h00) else $error("read not refused");
  a_ser2_bit_zero: assert property (
    cfg_rd_hit && pidx == 8'h25 |-> !cfg_rdata[0])
    else $error("serial two base bit0 set");
  a_rsvd_read_zero: assert property (
    cfg_rd_hit |-> !(pidx == 8'h29 && cfg_rdata[7:5] != 3'h0)
    && !(pidx == 8'h2C && cfg_rdata[7:4] != 4'h0)
    && !(pidx == 8'h2A && cfg_rdata != 8'h00))
    else $error("reserved bits read nonzero");
  a_ta_write: assert property (
    acc && cfg_wr_en && config_index_register == 8'h2D
    |=> ir_turnaround_timeout == $past(cfg_wdata))
    else $error("turnaround write lost");
  a_ta_scale: assert property (
    clk_en |=> ir_turnaround_cycles ==
    $past(ir_turnaround_timeout) * TA_STEP_CYCLES)
    else $error("turnaround cycles wrong");
  a_pin_func_lag: assert property (
    w29 ##1 (clk_en && !w29) |=> ir_pin_function_select ==
    $past(cfg_wdata[4], 2)) else $error("pin function not copied");
  a_ser2_qualify: assert property (
    second_serial_port_sel |-> !chip_select_n && !host_addr[10]
    && host_addr[9:8] != 2'h0) else $error("serial two select bad");
  a_fir_qualify: assert property (
    fast_ir_engine_sel |-> !chip_select_n && host_addr[10:8] != 3'h0)
    else $error("fast IR select bad");
  c_ta_read: cover property (cfg_rd_hit && pidx == 8'h2D);
  c_ser2_sel: cover property (second_serial_port_sel);
  c_fir_sel: cover property (fast_ir_engine_sel);
endmodule

bind rcr_config_regs rcr_monitor #(.TA_STEP_CYCLES(TA_STEP_CYCLES)) u_mon (
  .sys_clk, .rst, .clk_en, .config_mode, .config_index_register,
  .cfg_wr_en, .cfg_rd_en, .cfg_wdata, .cfg_rdata, .cfg_rd_hit,
  .chip_select_n, .host_addr, .second_serial_port_sel,
  .fast_ir_engine_sel, .ir_pin_function_select, .ir_turnaround_timeout,
  .ir_turnaround_cycles);
`default_nettype wire

// File: sim/resource_config_registers_tb.sv
`default_nettype none
module resource_config_registers_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Short step keeps the scaled turnaround count readable in sim
  localparam logic [14:0] TA = 15'h0004;
  logic sys_clk, rst, clk_en, config_mode, wr, rd, chip_select_n, etw;
  logic [7:0] idx, wd, etd;
  logic [10:0] host_addr;
  logic [9:0] src;
  logic [6:0] e;
  wire [7:0] cfg_rdata, ir_turnaround_timeout;
  wire cfg_rd_hit, s2s, s2e, fs, fe, ir_pin_function_select;
  wire [2:0] s2r, fr, dq, dqe, dpin;
  wire [6:0] iq, iqe, ipin;
  wire [22:0] ir_turnaround_cycles;
  int miscompares, tests_run, k;
  logic [7:0] ri [4] = '{8'h25, 8'h29, 8'h2C, 8'h2A};
  logic [7:0] re [4] = '{8'hFE, 8'h1F, 8'h0F, 8'h00};

  rcr_config_regs #(.TA_STEP_CYCLES(TA)) DUT (
    .sys_clk, .rst, .clk_en, .config_mode,
    .config_index_register(idx), .cfg_wr_en(wr), .cfg_rd_en(rd),
    .cfg_wdata(wd), .cfg_rdata, .cfg_rd_hit, .chip_select_n, .host_addr,
    .second_serial_port_sel(s2s), .second_serial_port_reg(s2r),
    .second_serial_port_enabled(s2e), .fast_ir_engine_sel(fs),
    .fast_ir_engine_reg(fr), .fast_ir_engine_enabled(fe),
    .disk_controller_drq(src[9]), .parallel_drq(src[8]),
    .fast_ir_engine_drq(src[7]), .dma_request_output(dq),
    .dma_request_oe(dqe), .disk_controller_irq(src[6]),
    .parallel_irq(src[5]), .first_serial_port_irq(src[4]),
    .first_serial_gate(src[3]), .second_serial_port_irq(src[2]),
    .second_serial_gate(src[1]), .external_interrupt_input(src[0]),
    .irq_line_out(iq), .irq_line_oe(iqe), .ir_pin_function_select,
    .engine_ta_wr_en(etw), .engine_ta_wdata(etd),
    .ir_turnaround_timeout, .ir_turnaround_cycles);
  rcr_host_side HOST (.irq_out(iq), .irq_oe(iqe), .drq_out(dq),
    .drq_oe(dqe), .irq_pin(ipin), .drq_pin(dpin));

  function automatic logic [6:0] ex(input int c);
    if (c == 8)
      return 7'h40;
    if (c >= 1 && c <= 6)
      return 7'(1 << (c - 1));
    return 7'h00;
  endfunction
  task chk(input string n, input logic [22:0] x, g);
    tests_run++;
    if (g !== x)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask
  task wrc(input logic [7:0] i, d);
    @(posedge sys_clk);
    wr <= 1;
    idx <= i;
    wd <= d;
    @(posedge sys_clk);
    wr <= 0;
  endtask
  task rdc(input logic [7:0] i, x, input logic h);
    @(posedge sys_clk);
    rd <= 1;
    idx <= i;
    @(posedge sys_clk);
    rd <= 0;
    @(negedge sys_clk);
    chk("cfg_rdata", x, cfg_rdata);
    chk("cfg_rd_hit", h, cfg_rd_hit);
  endtask
  task hd(input logic c, input logic [10:0] a, input logic x2, xf);
    @(posedge sys_clk);
    chip_select_n <= c;
    host_addr <= a;
    @(negedge sys_clk);
    chk("ser2_sel", x2, s2s);
    chk("fir_sel", xf, fs);
    chk("ser2_reg", a[2:0], s2r);
    chk("fir_reg", a[2:0], fr);
  endtask
  task ck2(input logic [6:0] xo, xp);
    @(negedge sys_clk);
    chk("irq_oe", xo, iqe);
    chk("irq_pin", xp, ipin);
  endtask
  task end_of_test;
    $display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    sys_clk = 0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial
  begin
    #20000;
    miscompares++;
    end_of_test();
  end
  initial
  begin
    rst = 1;
    clk_en = 1;
    config_mode = 1;
    wr = 0;
    rd = 0;
    idx = 0;
    wd = 0;
    chip_select_n = 1;
    host_addr = 0;
    src = 10'h3FF;
    etw = 0;
    etd = 0;
    repeat (8) @(posedge sys_clk);
    rst <= 0;
    for (k = 0; k < 9; k++)
      rdc(8'h25 + k, k == 8 ? 8'h03 : 8'h00, 1);
    @(posedge sys_clk);
    config_mode <= 0;
    wrc(8'h25, 8'hF8);
    rdc(8'h25, 8'h00, 0);
    @(posedge sys_clk);
    config_mode <= 1;
    rdc(8'h25, 8'h00, 1);
    rdc(8'h2E, 8'h00, 0);
    for (k = 0; k < 4; k++)
    begin
      wrc(ri[k], 8'hFF);
      rdc(ri[k], re[k], 1);
    end
    chk("ir_pin_function_select", 1, ir_pin_function_select);
    wrc(8'h25, 8'hFE);
    wrc(8'h2B, 8'hFF);
    hd(0, 11'h3F9, 1, 0);
    hd(0, 11'h7FA, 0, 1);
    hd(1, 11'h3F9, 0, 0);
    wrc(8'h25, 8'h3E);
    wrc(8'h2B, 8'h20);
    hd(0, 11'h0F8, 0, 0);
    chk("ser2_enabled", 0, s2e);
    hd(0, 11'h100, 0, 1);
    wrc(8'h2B, 8'h1F);
    hd(0, 11'h0F8, 0, 0);
    chk("fir_enabled", 0, fe);
    for (k = 0; k < 4; k++)
    begin
      wrc(8'h2C, 8'(k));
      @(negedge sys_clk);
      e = ex(k);
      chk("dma_oe", e[2:0], dqe);
      chk("dma_pin", e[2:0], dpin);
    end
    wrc(8'h2C, 8'h00);
    wrc(8'h26, 8'h21);
    @(negedge sys_clk);
    chk("dma_oe", 3'h3, dqe);
    for (k = 0; k < 9; k++)
    begin
      wrc(8'h27, 8'(k));
      ck2(ex(k), ex(k));
    end
    wrc(8'h27, 8'h30);
    ck2(7'h04, 7'h04);
    wrc(8'h27, 8'h00);
    wrc(8'h29, 8'h18);
    ck2(7'h40, 7'h40);
    @(negedge sys_clk);
    chk("ir_pin_function_select", 1, ir_pin_function_select);
    wrc(8'h29, 8'h00);
    // Pin select follows the register one cycle late
    @(negedge sys_clk);
    chk("ir_pin_function_select", 1, ir_pin_function_select);
    @(negedge sys_clk);
    chk("ir_pin_function_select", 0, ir_pin_function_select);
    wrc(8'h28, 8'h10);
    wrc(8'h28, 8'h1F);
    @(posedge sys_clk);
    src <= 10'h006;
    ck2(7'h01, 7'h01);
    @(posedge sys_clk);
    src <= 10'h002;
    ck2(7'h01, 7'h00);
    wrc(8'h28, 8'h12);
    @(posedge sys_clk);
    src <= 10'h00E;
    ck2(7'h03, 7'h02);
    wrc(8'h2D, 8'h0A);
    rdc(8'h2D, 8'h0A, 1);
    chk("ta_cycles", 23'h0A * TA, ir_turnaround_cycles);
    @(posedge sys_clk);
    etw <= 1;
    etd <= 8'h07;
    @(posedge sys_clk);
    etw <= 0;
    rdc(8'h2D, 8'h07, 1);
    // A frozen cycle must not take a write
    @(posedge sys_clk);
    clk_en <= 0;
    wrc(8'h2D, 8'h55);
    @(posedge sys_clk);
    clk_en <= 1;
    rdc(8'h2D, 8'h07, 1);
    // Mid-run reset brings the twin back to its power-up value
    @(posedge sys_clk);
    rst <= 1;
    repeat (2) @(posedge sys_clk);
    rst <= 0;
    ck2(7'h00, 7'h00);
    rdc(8'h2D, 8'h03, 1);
    chk("ta_cycles", 23'h03 * TA, ir_turnaround_cycles);
    end_of_test();
  end
endmodule
`default_nettype wire
